// ===== dv/hsp_host_model.sv
`timescale 1ns/1ps
// ====
// host side of the serial line
module hsp_host_model (
    input wire logic mclk,
    input wire logic txLine,
    output logic rxLine
);
    int bitCyc = 20;
    logic [7:0] got[$];
    logic ninth[$];
    initial rxLine = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxLine <= f[i];
            repeat (bitCyc) @(posedge mclk);
        end
    endtask
    always begin
        logic [7:0] b;
        @(negedge txLine);
        repeat (bitCyc / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitCyc) @(posedge mclk);
            b[i] = txLine;
        end
        repeat (bitCyc) @(posedge mclk);
        // parity bit, or the stop bit when parity is off
        ninth.push_back(txLine);
        got.push_back(b);
    end
endmodule

// ===== dv/test_host_serial_port_config.sv
`timescale 1ns/1ps
module test_host_serial_port_config;
    logic mclk = 0, rst_n = 0, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
    logic ctsIn = 1, rtsIn = 0, awR, wR, bV, arR, rV, serIn, serOut;
    logic ctsO, ctsE, rtsO, rtsE, pkt;
    logic [7:0] awA = 0, arA = 0;
    logic [31:0] wD = 0, rD, d;
    logic [1:0] bRsp, rRsp, r;
    int mismatches = 0, tests_run = 0, seed = 32'h104C, v, n;
    int bad[4] = '{0, 11, 32'h5B8, 32'h5B8D81};
    int unsigned mdl[int];
    logic [7:0] sent[$];
    initial forever #25 mclk = ~mclk;
    hsp_serial_port DUT (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_bresp(bRsp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV),
        .s_axi_rready(rRdy), .serialIn(serIn), .serialOut(serOut),
        .ctsPinIn(ctsIn), .ctsPinOut(ctsO), .ctsPinOe(ctsE),
        .rtsPinIn(rtsIn), .rtsPinOut(rtsO), .rtsPinOe(rtsE),
        .packetClose(pkt));
    hsp_host_model P (.mclk(mclk), .txLine(serOut), .rxLine(serIn));
    task automatic wrap_up();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // sampled mid-cycle: inputs only move just after rising edges
    task automatic waitHi(ref logic s);
        int k = 0;
        do @(negedge mclk); while (s !== 1'b1 && ++k < 5000);
        if (k == 5000) begin mismatches++; wrap_up(); end
    endtask
    task automatic waitRx();
        int k;
        for (k = 0; k < 900 && P.got.size() == 0; k++) @(posedge mclk);
        if (k == 900) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] e);
        @(posedge mclk);
        awA <= a; wD <= x; awV <= 1; wV <= 1; bRdy <= 1;
        waitHi(awR);
        @(posedge mclk);
        awV <= 0; wV <= 0;
        waitHi(bV);
        r = bRsp;
        @(posedge mclk);
        bRdy <= 0;
        cmp(32'(r), 32'(e));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] e);
        @(posedge mclk);
        arA <= a; arV <= 1; rRdy <= 1;
        waitHi(arR);
        @(posedge mclk);
        arV <= 0;
        waitHi(rV);
        d = rD;
        r = rRsp;
        @(posedge mclk);
        rRdy <= 0;
        cmp(32'(r), 32'(e));
    endtask
    task automatic chk(input int a);
        rd(8'(a), 2'h0);
        cmp(d, mdl[a]);
    endtask
    task automatic set(input int a, input int x);
        wr(8'(a), x, 2'h0);
        mdl[a] = x;
        chk(a);
    endtask
    // ====
    // main sequence
    initial begin
        mdl = '{0: 3, 4: 0, 8: 3, 12: 32'h7F3, 16: 1, 20: 32'h20};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (mdl[a]) chk(a);
        for (v = 1; v <= 10; v++) set(0, v);
        for (v = 0; v < 4; v++) wr(8'h00, bad[v], 2'h2);
        chk(0);
        set(0, 32'h5B9);
        set(0, 32'h5B8D80);
        repeat (4) begin
            v = $random(seed);
            set(4, v[4] << 4 | v[1:0] % 3);
            set(8, v[15:8]);
            set(12, 32'h11 + v[14:4] % 32'h813);
            set(16, v[22:20] | 1);
            set(20, v[25:24] % 3 << 4 | v[27:26] % 3);
        end
        wr(8'h0C, 32'h824, 2'h2);
        wr(8'h24, 0, 2'h2);
        chk(12);
        set(4, 0); set(20, 0); set(8, 1); set(0, 32'hF4240);
        for (v = 4; v < 6; v++) begin
            set(16, v << 4 | v);
            cmp({ctsE, ctsO, rtsE, rtsO}, {1'b1, v[0], 1'b1, v[0]});
        end
        set(16, 7);
        v = $random(seed);
        wr(8'h1C, v[7:0], 2'h0);
        repeat (100) @(posedge mclk);
        cmp(ctsO, 1);
        waitRx();
        cmp(P.got.pop_front(), v[7:0]);
        cmp(P.ninth.pop_front(), 1);
        repeat (20) @(posedge mclk);
        cmp(ctsO, 0);
        set(16, 6);
        cmp(ctsO, 1);
        set(4, 2);
        wr(8'h1C, v[15:8], 2'h0);
        waitRx();
        cmp(P.got.pop_front(), v[15:8]);
        cmp(P.ninth.pop_front(), ~^v[15:8]);
        set(4, 0);
        set(16, 1); set(12, 32'h11);
        for (v = 0; v < 17; v++) begin
            sent.push_back($random(seed));
            P.send(sent[v]);
        end
        for (n = 0; n < 2500 && pkt !== 1'b1; n++) @(negedge mclk);
        cmp(n > 1900 && n < 2200, 1);
        cmp(ctsO, 1);
        rd(8'h18, 2'h0);
        cmp(d[19:8], 17);
        cmp(d[3:0], 4'hC);
        foreach (sent[i]) begin
            rd(8'h20, 2'h0);
            cmp(d[7:0], sent[i]);
        end
        cmp(ctsO, 0);
        set(8, 20);
        P.send(8'h5A);
        for (n = 0; n < 5000 && pkt !== 1'b1; n++) @(negedge mclk);
        cmp(n > 3800 && n < 4200, 1);
        rd(8'h20, 2'h0);
        cmp(d[7:0], 8'h5A);
        wrap_up();
    end
endmodule

// ===== logic/hsp_baud_gen.sv
`timescale 1ns/1ps
`include "hsp_defs.svh"
module hsp_baud_gen #(
    parameter int CLK_HZ = `HSP_CLK_HZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [23:0] baudRate,
    output logic tick16
);
    // ===========================================
    // fractional accumulator, 16 ticks per bit
    // trade-off: jitter of one mclk instead of a coarse integer divider
    logic [31:0] acc_ff, nxt_acc;
    logic tick_ff, nxt_tick;
    logic [32:0] sum;
    always_comb begin
        sum = {1'b0, acc_ff} + {5'h00, baudRate, 4'h0};
        nxt_tick = 1'b0;
        nxt_acc = sum[31:0];
        if (sum >= 33'(CLK_HZ)) begin
            nxt_acc = 32'(sum - 33'(CLK_HZ));
            nxt_tick = 1'b1;
        end
        // limitation: ticks top out at one per mclk, so the excess of a
        // rate above mclk/16 is dropped instead of piling up
        if (sum >= 33'(2 * CLK_HZ)) begin
            nxt_acc = 32'h0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            tick_ff <= nxt_tick;
        end
    end
    assign tick16 = tick_ff;
endmodule

// ===== logic/hsp_defs.svh
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH
// ===========================================
// register byte offsets
`define HSP_OFF_BAUD 8'h00
`define HSP_OFF_FRAME 8'h04
`define HSP_OFF_SILENCE 8'h08
`define HSP_OFF_THRESH 8'h0C
`define HSP_OFF_PINS 8'h10
`define HSP_OFF_MODE 8'h14
`define HSP_OFF_STATUS 8'h18
`define HSP_OFF_TXDATA 8'h1C
`define HSP_OFF_RXDATA 8'h20
// ===========================================
// reset values
`define HSP_RST_BAUD 24'h000003
`define HSP_RST_PARITY 2'h0
`define HSP_RST_STOP 1'b0
`define HSP_RST_SILENCE 8'h03
`define HSP_RST_THRESH 12'h7F3
`define HSP_RST_CTSFN 3'h1
`define HSP_RST_RTSFN 3'h0
`define HSP_RST_HOSTMODE 2'h0
`define HSP_RST_RXFMT 2'h2
// ===========================================
// ranges and timing
`define HSP_STD_MAX 24'h00000A
`define HSP_LIT_MIN 24'h0005B9
`define HSP_LIT_MAX 24'h5B8D80
`define HSP_THR_MIN 12'h011
`define HSP_THR_MAX 12'h823
`define HSP_CLK_HZ 20000000
`define HSP_MIN_SIL_US 100
`define HSP_MIN_SIL_CYC ((`HSP_MIN_SIL_US * (`HSP_CLK_HZ / 1000000)))
`endif

// ===== logic/hsp_pkg.sv
package hsp_pkg;
    typedef enum logic [1:0] {
        HSP_PAR_NONE = 2'h0,
        HSP_PAR_EVEN = 2'h1,
        HSP_PAR_ODD = 2'h2
    } hsp_parity_t;
    typedef enum logic [2:0] {
        HSP_PIN_OFF = 3'h0,
        HSP_PIN_FLOW = 3'h1,
        HSP_PIN_UNUSED = 3'h2,
        HSP_PIN_INPUT = 3'h3,
        HSP_PIN_LOW = 3'h4,
        HSP_PIN_HIGH = 3'h5,
        HSP_PIN_DE_LOW = 3'h6,
        HSP_PIN_DE_HIGH = 3'h7
    } hsp_pinfn_t;
    typedef enum logic [3:0] {
        HSP_TX_IDLE = 4'h1,
        HSP_TX_SHIFT = 4'h2,
        HSP_TX_PAR = 4'h4,
        HSP_TX_STOP = 4'h8
    } hsp_txst_t;
endpackage

// ===== logic/hsp_serial_port.sv
`timescale 1ns/1ps
`include "hsp_defs.svh"
module hsp_serial_port #(
    parameter int CLK_HZ = `HSP_CLK_HZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serialIn,
    output logic serialOut,
    input wire logic ctsPinIn,
    output logic ctsPinOut,
    output logic ctsPinOe,
    input wire logic rtsPinIn,
    output logic rtsPinOut,
    output logic rtsPinOe,
    output logic packetClose
);
    localparam logic [23:0] CYC_SIL = 24'(`HSP_MIN_SIL_CYC);
    // ===========================================
    // helpers
    function automatic logic [23:0] codeRate(input logic [3:0] c);
        logic [23:0] r;
        r = 24'd9600;
        unique case (c)
            4'h1: r = 24'd2400;
            4'h2: r = 24'd4800;
            4'h3: r = 24'd9600;
            4'h4: r = 24'd19200;
            4'h5: r = 24'd38400;
            4'h6: r = 24'd57600;
            4'h7: r = 24'd115200;
            4'h8: r = 24'd230400;
            4'h9: r = 24'd460800;
            4'hA: r = 24'd921600;
            default: r = 24'd9600;
        endcase
        return r;
    endfunction
    function automatic logic parityOf(input logic [7:0] d,
        input logic [1:0] p);
        return (p == hsp_pkg::HSP_PAR_ODD) ? ~^d : ^d;
    endfunction
    // ===========================================
    // configuration registers
    logic [23:0] baud_ff, nxt_baud;
    logic [1:0] parity_ff, nxt_parity;
    logic stop_ff, nxt_stop;
    logic [7:0] silence_ff, nxt_silence;
    logic [11:0] thresh_ff, nxt_thresh;
    logic [2:0] ctsFn_ff, nxt_ctsFn;
    logic [2:0] rtsFn_ff, nxt_rtsFn;
    logic [1:0] hostMode_ff, nxt_hostMode;
    logic [1:0] rxFmt_ff, nxt_rxFmt;
    logic bvalid_ff, nxt_bvalid, bslv_ff, nxt_bslv;
    logic rvalid_ff, nxt_rvalid, rslv_ff, nxt_rslv;
    logic [31:0] rdata_ff, nxt_rdata;
    logic txLoad;
    logic [7:0] txByte;
    logic rxPop;
    logic [23:0] wv;
    logic wrGo, rdGo;
    logic [11:0] rxCount_ff;
    logic [7:0] rxHead;
    logic txBusy;
    logic [1:0] rxS_ff, ctsS_ff, rtsS_ff;
    logic ctsPinS_ff, rtsPinS_ff, rxLine;
    assign wrGo = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    assign s_axi_awready = wrGo;
    assign s_axi_wready = wrGo;
    assign rdGo = s_axi_arvalid && !rvalid_ff;
    assign s_axi_arready = rdGo;
    assign wv = s_axi_wdata[23:0];
    always_comb begin
        nxt_baud = baud_ff;
        nxt_parity = parity_ff;
        nxt_stop = stop_ff;
        nxt_silence = silence_ff;
        nxt_thresh = thresh_ff;
        nxt_ctsFn = ctsFn_ff;
        nxt_rtsFn = rtsFn_ff;
        nxt_hostMode = hostMode_ff;
        nxt_rxFmt = rxFmt_ff;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bslv = bslv_ff;
        txLoad = 1'b0;
        txByte = s_axi_wdata[7:0];
        if (wrGo) begin
            nxt_bvalid = 1'b1;
            nxt_bslv = 1'b0;
            unique case (s_axi_awaddr)
                `HSP_OFF_BAUD: begin
                    if (wv > `HSP_STD_MAX) begin
                        if (wv >= `HSP_LIT_MIN && wv <= `HSP_LIT_MAX) begin
                            nxt_baud = wv;
                        end else begin
                            nxt_bslv = 1'b1;
                        end
                    end else if (wv != 24'h0) begin
                        nxt_baud = wv;
                    end else begin
                        nxt_bslv = 1'b1;
                    end
                end
                `HSP_OFF_FRAME: begin
                    if (s_axi_wdata[1:0] != 2'h3) begin
                        nxt_parity = s_axi_wdata[1:0];
                    end else begin
                        nxt_bslv = 1'b1;
                    end
                    nxt_stop = s_axi_wdata[4];
                end
                `HSP_OFF_SILENCE: nxt_silence = s_axi_wdata[7:0];
                `HSP_OFF_THRESH: begin
                    if (s_axi_wdata[11:0] >= `HSP_THR_MIN &&
                        s_axi_wdata[11:0] <= `HSP_THR_MAX) begin
                        nxt_thresh = s_axi_wdata[11:0];
                    end else begin
                        nxt_bslv = 1'b1;
                    end
                end
                `HSP_OFF_PINS: begin
                    nxt_ctsFn = s_axi_wdata[2:0];
                    // rts function, 6 and up refused
                    if (s_axi_wdata[6:4] <= 3'h5) begin
                        nxt_rtsFn = s_axi_wdata[6:4];
                    end else begin
                        nxt_bslv = 1'b1;
                    end
                end
                `HSP_OFF_MODE: begin
                    if (s_axi_wdata[1:0] != 2'h3) begin
                        nxt_hostMode = s_axi_wdata[1:0];
                    end
                    if (s_axi_wdata[5:4] != 2'h3) begin
                        nxt_rxFmt = s_axi_wdata[5:4];
                    end
                end
                `HSP_OFF_TXDATA: begin
                    txLoad = !txBusy;
                    nxt_bslv = txBusy;
                end
                `HSP_OFF_STATUS, `HSP_OFF_RXDATA: nxt_bslv = 1'b1;
                default: nxt_bslv = 1'b1;
            endcase
        end
    end
    always_comb begin
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rslv = rslv_ff;
        nxt_rdata = rdata_ff;
        rxPop = 1'b0;
        if (rdGo) begin
            nxt_rvalid = 1'b1;
            nxt_rslv = 1'b0;
            nxt_rdata = 32'h0;
            unique case (s_axi_araddr)
                `HSP_OFF_BAUD: nxt_rdata = {8'h0, baud_ff};
                `HSP_OFF_FRAME: nxt_rdata = {27'h0, stop_ff, 2'h0, parity_ff};
                `HSP_OFF_SILENCE: nxt_rdata = {24'h0, silence_ff};
                `HSP_OFF_THRESH: nxt_rdata = {20'h0, thresh_ff};
                `HSP_OFF_PINS: nxt_rdata = {25'h0, rtsFn_ff, 1'b0, ctsFn_ff};
                `HSP_OFF_MODE: nxt_rdata = {26'h0, rxFmt_ff, 2'h0, hostMode_ff};
                `HSP_OFF_STATUS: nxt_rdata = {12'h0, rxCount_ff, 4'h0,
                    ctsPinOut, ctsPinS_ff, rtsPinS_ff, txBusy};
                `HSP_OFF_RXDATA: begin
                    nxt_rdata = {24'h0, rxHead};
                    rxPop = 1'b1;
                end
                `HSP_OFF_TXDATA: nxt_rdata = 32'h0;
                default: nxt_rslv = 1'b1;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            baud_ff <= `HSP_RST_BAUD;
            parity_ff <= `HSP_RST_PARITY;
            stop_ff <= `HSP_RST_STOP;
            silence_ff <= `HSP_RST_SILENCE;
            thresh_ff <= `HSP_RST_THRESH;
            ctsFn_ff <= `HSP_RST_CTSFN;
            rtsFn_ff <= `HSP_RST_RTSFN;
            hostMode_ff <= `HSP_RST_HOSTMODE;
            rxFmt_ff <= `HSP_RST_RXFMT;
            bvalid_ff <= 1'b0;
            bslv_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rslv_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            baud_ff <= nxt_baud;
            parity_ff <= nxt_parity;
            stop_ff <= nxt_stop;
            silence_ff <= nxt_silence;
            thresh_ff <= nxt_thresh;
            ctsFn_ff <= nxt_ctsFn;
            rtsFn_ff <= nxt_rtsFn;
            hostMode_ff <= nxt_hostMode;
            rxFmt_ff <= nxt_rxFmt;
            bvalid_ff <= nxt_bvalid;
            bslv_ff <= nxt_bslv;
            rvalid_ff <= nxt_rvalid;
            rslv_ff <= nxt_rslv;
            rdata_ff <= nxt_rdata;
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bslv_ff ? 2'h2 : 2'h0;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rslv_ff ? 2'h2 : 2'h0;
    assign s_axi_rdata = rdata_ff;
    // ===========================================
    // bit clock
    logic tick16;
    logic [23:0] rate;
    assign rate = (baud_ff > `HSP_STD_MAX) ? baud_ff : codeRate(baud_ff[3:0]);
    hsp_baud_gen #(.CLK_HZ(CLK_HZ)) u_baud (
        .mclk(mclk),
        .rst_n(rst_n),
        .baudRate(rate),
        .tick16(tick16)
    );
    // ===========================================
    // pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxS_ff <= 2'h3;
            ctsS_ff <= 2'h3;
            rtsS_ff <= 2'h3;
        end else begin
            rxS_ff <= {rxS_ff[0], serialIn};
            ctsS_ff <= {ctsS_ff[0], ctsPinIn};
            rtsS_ff <= {rtsS_ff[0], rtsPinIn};
        end
    end
    assign rxLine = rxS_ff[1];
    assign ctsPinS_ff = ctsS_ff[1];
    assign rtsPinS_ff = rtsS_ff[1];
    // ===========================================
    // transmitter
    hsp_pkg::hsp_txst_t tst_ff, nxt_tst;
    logic [10:0] tsh_ff, nxt_tsh;
    logic [3:0] tph_ff, nxt_tph, tbit_ff, nxt_tbit;
    logic txo_ff, nxt_txo;
    logic hostHold;
    assign hostHold = (rtsFn_ff == hsp_pkg::HSP_PIN_FLOW) && rtsPinS_ff;
    assign txBusy = (tst_ff != hsp_pkg::HSP_TX_IDLE) || hostHold;
    always_comb begin
        nxt_tst = tst_ff;
        nxt_tsh = tsh_ff;
        nxt_tph = tph_ff;
        nxt_tbit = tbit_ff;
        nxt_txo = txo_ff;
        unique case (tst_ff)
            hsp_pkg::HSP_TX_IDLE: begin
                nxt_txo = 1'b1;
                // start bit then data lsb first
                if (txLoad) begin
                    nxt_tsh = {txByte, 1'b0, 2'h0};
                    nxt_txo = 1'b0;
                    nxt_tph = 4'h0;
                    nxt_tbit = 4'h8;
                    nxt_tst = hsp_pkg::HSP_TX_SHIFT;
                end
            end
            default: if (tick16) begin
                nxt_tph = tph_ff + 4'h1;
                if (tph_ff == 4'hF) begin
                    unique case (tst_ff)
                        hsp_pkg::HSP_TX_SHIFT: begin
                            nxt_txo = tsh_ff[3];
                            // rotate keeps the byte whole for the parity bit
                            nxt_tsh = {tsh_ff[3], tsh_ff[10:4], tsh_ff[2:0]};
                            nxt_tbit = tbit_ff - 4'h1;
                            if (tbit_ff == 4'h0) begin
                                nxt_txo = parityOf(tsh_ff[10:3], parity_ff);
                                nxt_tst = (parity_ff == hsp_pkg::HSP_PAR_NONE)
                                    ? hsp_pkg::HSP_TX_STOP : hsp_pkg::HSP_TX_PAR;
                                if (parity_ff == hsp_pkg::HSP_PAR_NONE) begin
                                    nxt_txo = 1'b1;
                                end
                                nxt_tbit = {3'h0, stop_ff};
                            end
                        end
                        hsp_pkg::HSP_TX_PAR: begin
                            nxt_txo = 1'b1;
                            nxt_tst = hsp_pkg::HSP_TX_STOP;
                        end
                        default: begin
                            nxt_tbit = tbit_ff - 4'h1;
                            if (tbit_ff == 4'h0) begin
                                nxt_tst = hsp_pkg::HSP_TX_IDLE;
                            end
                        end
                    endcase
                end
            end
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tst_ff <= hsp_pkg::HSP_TX_IDLE;
            tsh_ff <= 11'h0;
            tph_ff <= 4'h0;
            tbit_ff <= 4'h0;
            txo_ff <= 1'b1;
        end else begin
            tst_ff <= nxt_tst;
            tsh_ff <= nxt_tsh;
            tph_ff <= nxt_tph;
            tbit_ff <= nxt_tbit;
            txo_ff <= nxt_txo;
        end
    end
    assign serialOut = txo_ff;
    // ===========================================
    // receiver, buffer count and packet timer
    // limitation: the buffer holds 4095 bytes, a full one drops new bytes
    logic [3:0] rph_ff, nxt_rph, rbit_ff, nxt_rbit;
    logic rbusy_ff, nxt_rbusy;
    logic [8:0] rsh_ff, nxt_rsh;
    logic [11:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic rxPush;
    logic [7:0] rxMem [0:4095];
    logic [11:0] nxt_rxCount;
    logic [23:0] idle_ff, nxt_idle;
    logic [15:0] chr_ff, nxt_chr;
    logic pend_ff, nxt_pend, close_ff, nxt_close, rxDone;
    logic [3:0] frameBits;
    logic [3:0] lastBit;
    assign frameBits = 4'hA + {3'h0, parity_ff != 2'h0} + {3'h0, stop_ff};
    assign lastBit = (parity_ff != 2'h0) ? 4'hA : 4'h9;
    always_comb begin
        nxt_rph = rph_ff;
        nxt_rbit = rbit_ff;
        nxt_rbusy = rbusy_ff;
        nxt_rsh = rsh_ff;
        rxDone = 1'b0;
        if (!rbusy_ff) begin
            if (!rxLine) begin
                nxt_rbusy = 1'b1;
                nxt_rph = 4'h8;
                nxt_rbit = 4'h0;
            end
        end else if (tick16) begin
            nxt_rph = rph_ff + 4'h1;
            if (rph_ff == 4'hF) begin
                // parity and stop samples stay out of the data
                if (rbit_ff <= 4'h8) begin
                    nxt_rsh = {rxLine, rsh_ff[8:1]};
                end
                nxt_rbit = rbit_ff + 4'h1;
                // done mid stop bit, so a low d7 is no new start
                if (rbit_ff == lastBit) begin
                    nxt_rbusy = 1'b0;
                    rxDone = 1'b1;
                end
            end
        end
        nxt_rxCount = rxCount_ff;
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        rxPush = rxDone && rxCount_ff != 12'hFFF;
        if (rxPush) begin
            nxt_rxCount = nxt_rxCount + 12'h1;
            nxt_wrPtr = wrPtr_ff + 12'h1;
        end
        if (rxPop && rxCount_ff != 12'h0) begin
            nxt_rxCount = nxt_rxCount - 12'h1;
            nxt_rdPtr = rdPtr_ff + 12'h1;
        end
        nxt_pend = pend_ff || rxDone;
        nxt_close = 1'b0;
        nxt_idle = (rxDone || rbusy_ff) ? 24'h0 : idle_ff + 24'h1;
        nxt_chr = chr_ff;
        if (rxDone || rbusy_ff) begin
            nxt_chr = 16'h0;
        end else if (tick16 && chr_ff != 16'hFFFF) begin
            nxt_chr = chr_ff + 16'h1;
        end
        // silence in char times and minimum time
        if (pend_ff && !rxDone && !rbusy_ff && idle_ff >= CYC_SIL &&
            chr_ff >= {4'h0, silence_ff, 4'h0} * {12'h0, frameBits}) begin
            nxt_close = 1'b1;
            nxt_pend = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rph_ff <= 4'h0;
            rbit_ff <= 4'h0;
            rbusy_ff <= 1'b0;
            rsh_ff <= 9'h0;
            wrPtr_ff <= 12'h0;
            rdPtr_ff <= 12'h0;
            rxCount_ff <= 12'h0;
            idle_ff <= 24'h0;
            chr_ff <= 16'h0;
            pend_ff <= 1'b0;
            close_ff <= 1'b0;
        end else begin
            rph_ff <= nxt_rph;
            rbit_ff <= nxt_rbit;
            rbusy_ff <= nxt_rbusy;
            rsh_ff <= nxt_rsh;
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            rxCount_ff <= nxt_rxCount;
            idle_ff <= nxt_idle;
            chr_ff <= nxt_chr;
            pend_ff <= nxt_pend;
            close_ff <= nxt_close;
        end
    end
    // buffer storage has no reset, the pointers say what is valid
    always_ff @(posedge mclk) begin
        if (rxPush) begin
            rxMem[wrPtr_ff] <= rsh_ff[8:1];
        end
    end
    assign rxHead = rxMem[rdPtr_ff];
    assign packetClose = close_ff;
    // ===========================================
    // pin multiplexing
    always_comb begin
        ctsPinOut = 1'b0;
        ctsPinOe = 1'b1;
        unique case (ctsFn_ff)
            // clear-to-send, active low on the pin
            hsp_pkg::HSP_PIN_FLOW: ctsPinOut = rxCount_ff >= thresh_ff;
            hsp_pkg::HSP_PIN_HIGH: ctsPinOut = 1'b1;
            hsp_pkg::HSP_PIN_LOW: ctsPinOut = 1'b0;
            // transmit enable while a character is out
            hsp_pkg::HSP_PIN_DE_LOW:
                ctsPinOut = tst_ff == hsp_pkg::HSP_TX_IDLE;
            hsp_pkg::HSP_PIN_DE_HIGH:
                ctsPinOut = tst_ff != hsp_pkg::HSP_TX_IDLE;
            // off, input and unused codes leave the pin floating
            default: ctsPinOe = 1'b0;
        endcase
        rtsPinOut = rtsFn_ff == hsp_pkg::HSP_PIN_HIGH;
        rtsPinOe = rtsFn_ff == hsp_pkg::HSP_PIN_HIGH ||
            rtsFn_ff == hsp_pkg::HSP_PIN_LOW;
    end
    // ===========================================
    // checks
    baud_default_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> baud_ff == 24'h3) else $error("baud default");
    cts_flow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctsFn_ff == 3'h1 && rxCount_ff >= thresh_ff |-> ctsPinOut && ctsPinOe)
        else $error("cts not deasserted");
    tx_enable_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctsFn_ff == 3'h7 && !serialOut |-> ctsPinOut) else $error("enable low");
    close_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        packetClose |-> $past(idle_ff) >= CYC_SIL) else $error("gap short");
    rts_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rtsPinOe |-> rtsFn_ff inside {3'h4, 3'h5}) else $error("rts drive");
    start_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        txLoad |=> !serialOut) else $error("no start bit");
    parity_reg_a: assert property (@(posedge mclk) disable iff (!rst_n)
        parity_ff != 2'h3) else $error("bad parity");
    lit_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
        baud_ff <= `HSP_LIT_MAX) else $error("rate range");
endmodule
